// file: common/ext_exec_defines.svh
`ifndef EXT_EXEC_DEFINES_SVH
`define EXT_EXEC_DEFINES_SVH

// register byte offsets
`define OFF_CMD     12'h000
`define OFF_ACC     12'h004
`define OFF_FLAGS   12'h008
`define OFF_TABLE_POINTER_LOW    12'h00C
`define OFF_TABLE_POINTER_HIGH    12'h010
`define OFF_TABLE_READ_UPPER_BYTE    12'h014
`define OFF_STAT    12'h018
`define OFF_PAGE    12'h01C

// memory windows: data memory at 0x100..0x17C, program memory at 0x800..0xFFC
`define DM_TAG      5'h02
`define PM_TAG      1'b1
`define DM_AW       5
`define PM_AW       9

// command word fields
`define CMD_W       13
`define CMD_OP_HI   3
`define CMD_OP_LO   0
`define CMD_BIT_HI  6
`define CMD_BIT_LO  4
`define CMD_ADR_HI  12
`define CMD_ADR_LO  8

// execution status fields
`define ST_BUSY     0
`define ST_SKIP     1
`define ST_CYC_HI   3
`define ST_CYC_LO   2

// operation codes
`define OP_SUBM     4'h0
`define OP_SWAP     4'h1
`define OP_SWAPA    4'h2
`define OP_SZ       4'h3
`define OP_SZA      4'h4
`define OP_SZBIT    4'h5
`define OP_TABRD    4'h6
`define OP_TABRDL   4'h7
`define OP_ITABRD   4'h8
`define OP_ITABRDL  4'h9
`define OP_XOR      4'hA
`define OP_XORM     4'hB

// misc
`define LAST_PAGE   1'b1
`define RD_LAT      2'h2
`define CYC_ONE     2'h1
`define CYC_TWO     2'h2
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define BYTE_RST    8'h00
`define CMD_RST     13'h0000

`endif

// file: common/ext_exec_pkg.sv
package ext_exec_pkg;

    typedef struct packed {
        logic cz;
        logic sc;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_s;

    typedef struct packed {
        logic [7:0] data;
        flags_s     flags;
        logic       wr_mem;
        logic       wr_acc;
        logic       skip;
    } alu_out_s;

    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH,
        S_EXEC,
        S_DUMMY
    } exec_state_e;

endpackage

// file: rtl/ext_exec_mem.sv
`timescale 1ns/10ps
module ext_exec_mem #(
    parameter int W  = 8,
    parameter int AW = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  wdata,
    output logic      [W-1:0]  rdata_q
);
    logic [W-1:0] mem [0:(1<<AW)-1];

    // array has no reset; contents are software's to load
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read-during-write returns the old word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[addr];
        end
    end
endmodule

// file: rtl/ext_exec_alu.sv
`timescale 1ns/10ps
`include "ext_exec_defines.svh"
module ext_exec_alu (
    input  wire logic [7:0]        acc,
    input  wire logic [7:0]        mem,
    input  wire logic [3:0]        op,
    input  wire logic [2:0]        bit_sel,
    input  ext_exec_pkg::flags_s   flags_in,
    output ext_exec_pkg::alu_out_s res
);
    import ext_exec_pkg::*;

    logic [8:0] diff;

    always_comb begin
        diff = {1'b0, acc} - {1'b0, mem};
        res = '0;
        res.flags = flags_in;
        res.data = mem;
        case (op)
            `OP_SUBM: begin
                res.data = diff[7:0];
                res.wr_mem = 1'b1;
                res.flags.c = ~diff[8];
                res.flags.ac = (acc[3:0] >= mem[3:0]);
                res.flags.z = (diff[7:0] == `BYTE_RST);
                res.flags.ov = (acc[7] != mem[7]) && (diff[7] != acc[7]);
                res.flags.sc = res.flags.ov ^ diff[7];
                res.flags.cz = res.flags.z;
            end
            `OP_SWAP: begin
                res.data = {mem[3:0], mem[7:4]};
                res.wr_mem = 1'b1;
            end
            `OP_SWAPA: begin
                res.data = {mem[3:0], mem[7:4]};
                res.wr_acc = 1'b1;
            end
            `OP_SZ: begin
                res.skip = (mem == `BYTE_RST);
            end
            `OP_SZA: begin
                res.wr_acc = 1'b1;
                res.skip = (mem == `BYTE_RST);
            end
            `OP_SZBIT: begin
                res.skip = ~mem[bit_sel];
            end
            `OP_XOR, `OP_XORM: begin
                res.data = acc ^ mem;
                res.flags.z = ((acc ^ mem) == `BYTE_RST);
                res.wr_acc = (op == `OP_XOR);
                res.wr_mem = (op == `OP_XORM);
            end
            default: begin
                res.skip = 1'b0;
            end
        endcase
    end
endmodule

// file: rtl/ext_exec_unit.sv
// Functional notes
// - subtract to memory, carry set unless negative
// - subtract updates wrap, zero, aux, carry, signed, chained
// - swap nibbles in place, flags untouched
// - swapped nibbles into accumulator, memory kept
// - skip when byte zero, two cycles
// - copy byte to accumulator, skip if zero
// - skip when selected bit zero, two cycles
// - table read current page via low pointer
// - table read last page via low pointer
// - increment low pointer, read via both pointers
// - increment low pointer, read last page
// - xor into accumulator, only zero flag
// - xor into memory, only zero flag
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ext_exec_defines.svh"
module ext_exec_unit (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic [11:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [11:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    import ext_exec_pkg::*;

    exec_state_e                state_q;
    logic [`CMD_W-1:0]          cmd_q;
    logic [7:0]                 acc_q;
    flags_s                     flags_q;
    logic [7:0]                 table_pointer_low_q;
    logic [0:0]                 table_pointer_high_q;
    logic [0:0]                 page_q;
    logic [7:0]                 table_read_upper_byte_q;
    logic                       skip_q;
    logic [1:0]                 cyc_q;
    logic                       wready_q;
    logic                       arready_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [1:0]                 rresp_q;
    logic [31:0]                rdata_q;
    logic [11:0]                rd_addr_q;
    logic [1:0]                 rd_cnt_q;
    logic                       idle;
    logic                       rd_busy;
    logic                       wr_go;
    logic                       rd_go;
    logic                       wr_fire;
    logic                       w_dm;
    logic                       w_pm;
    logic                       w_err;
    logic [31:0]                rd_d;
    logic                       rd_err;
    logic [3:0]                 op;
    logic                       is_tab;
    logic                       preinc;
    logic [7:0]                 table_pointer_low_nx;
    logic [`PM_AW-1:0]          pm_fetch;
    logic                       dm_we;
    logic [`DM_AW-1:0]          dm_addr;
    logic [7:0]                 dm_wdata;
    logic [7:0]                 dm_rdata;
    logic                       pm_we;
    logic [`PM_AW-1:0]          pm_addr;
    logic [15:0]                pm_rdata;
    alu_out_s                   alu;

    assign AWREADY = wready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RRESP   = rresp_q;
    assign RDATA   = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes: one write or one read at a time, never while executing
    assign idle    = (state_q == S_IDLE);
    assign rd_busy = (rd_cnt_q != 2'h0) || rvalid_q;
    assign wr_fire = wready_q;
    // both channels waited for so that address and data are taken together
    assign wr_go = !wready_q && AWVALID && WVALID && !bvalid_q && idle && !rd_busy
                   && !arready_q;
    assign rd_go = !arready_q && ARVALID && !rd_busy && idle && !wr_go && !wready_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else begin
            wready_q <= wr_go;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            arready_q <= 1'b0;
            rd_addr_q <= 12'h000;
            rd_cnt_q  <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= `RESP_OKAY;
            rdata_q   <= 32'h00000000;
        end else begin
            arready_q <= rd_go;
            if (arready_q) begin
                rd_addr_q <= ARADDR;
                rd_cnt_q  <= `RD_LAT;
            end else if (rd_cnt_q != 2'h0) begin
                rd_cnt_q <= rd_cnt_q - 2'h1;
            end
            // memory read data is registered, hence the extra wait
            if (rd_cnt_q == 2'h1) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_d;
                rresp_q  <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        w_dm  = 1'b0;
        w_pm  = 1'b0;
        w_err = 1'b0;
        if (AWADDR[11] == `PM_TAG) begin
            w_pm = 1'b1;
        end else if (AWADDR[11:7] == `DM_TAG) begin
            w_dm = 1'b1;
        end else begin
            case (AWADDR)
                `OFF_CMD, `OFF_ACC, `OFF_FLAGS, `OFF_TABLE_POINTER_LOW, `OFF_TABLE_POINTER_HIGH,
                `OFF_TABLE_READ_UPPER_BYTE, `OFF_STAT, `OFF_PAGE: w_err = 1'b0;
                default: w_err = 1'b1;
            endcase
        end
    end

    always_comb begin
        rd_d   = 32'h00000000;
        rd_err = 1'b0;
        if (rd_addr_q[11] == `PM_TAG) begin
            rd_d = {16'h0000, pm_rdata};
        end else if (rd_addr_q[11:7] == `DM_TAG) begin
            rd_d = {24'h000000, dm_rdata};
        end else begin
            case (rd_addr_q)
                `OFF_CMD:   rd_d = {19'h0, cmd_q};
                `OFF_ACC:   rd_d = {24'h000000, acc_q};
                `OFF_FLAGS: rd_d = {26'h0, flags_q};
                `OFF_TABLE_POINTER_LOW:  rd_d = {24'h000000, table_pointer_low_q};
                `OFF_TABLE_POINTER_HIGH:  rd_d = {31'h0, table_pointer_high_q};
                `OFF_TABLE_READ_UPPER_BYTE:  rd_d = {24'h000000, table_read_upper_byte_q};
                `OFF_STAT:  rd_d = {28'h0000000, cyc_q, skip_q, !idle};
                `OFF_PAGE:  rd_d = {31'h0, page_q};
                default:    rd_err = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // execution datapath
    assign op      = cmd_q[`CMD_OP_HI:`CMD_OP_LO];
    assign is_tab  = (op == `OP_TABRD) || (op == `OP_TABRDL) || (op == `OP_ITABRD)
                     || (op == `OP_ITABRDL);
    assign preinc  = (op == `OP_ITABRD) || (op == `OP_ITABRDL);
    assign table_pointer_low_nx = preinc ? table_pointer_low_q + 8'h01 : table_pointer_low_q;

    always_comb begin
        case (op)
            `OP_ITABRD:  pm_fetch = {table_pointer_high_q, table_pointer_low_nx};
            `OP_TABRDL:  pm_fetch = {`LAST_PAGE, table_pointer_low_nx};
            `OP_ITABRDL: pm_fetch = {`LAST_PAGE, table_pointer_low_nx};
            default:     pm_fetch = {page_q, table_pointer_low_nx};
        endcase
    end

    ext_exec_alu u_alu (
        .acc      (acc_q),
        .mem      (dm_rdata),
        .op       (op),
        .bit_sel  (cmd_q[`CMD_BIT_HI:`CMD_BIT_LO]),
        .flags_in (flags_q),
        .res      (alu)
    );

    // partial strobes on a memory word are dropped, never merged
    assign dm_we    = (state_q == S_EXEC) ? (is_tab || alu.wr_mem)
                      : (wr_fire && w_dm && WSTRB[0]);
    assign dm_wdata = (state_q == S_EXEC) ? (is_tab ? pm_rdata[7:0] : alu.data)
                      : WDATA[7:0];
    assign dm_addr  = !idle ? cmd_q[`CMD_ADR_HI:`CMD_ADR_LO]
                      : (rd_busy ? rd_addr_q[`DM_AW+1:2] : AWADDR[`DM_AW+1:2]);
    assign pm_we    = wr_fire && w_pm && (WSTRB[1:0] == 2'h3);
    assign pm_addr  = (state_q == S_FETCH) ? pm_fetch
                      : (rd_busy ? rd_addr_q[`PM_AW+1:2] : AWADDR[`PM_AW+1:2]);

    ext_exec_mem #(.W(8), .AW(`DM_AW)) u_dmem (
        .clk     (CLK),
        .rst_n   (RST_N),
        .we      (dm_we),
        .addr    (dm_addr),
        .wdata   (dm_wdata),
        .rdata_q (dm_rdata)
    );

    ext_exec_mem #(.W(16), .AW(`PM_AW)) u_pmem (
        .clk     (CLK),
        .rst_n   (RST_N),
        .we      (pm_we),
        .addr    (pm_addr),
        .wdata   (WDATA[15:0]),
        .rdata_q (pm_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: fetch operands, execute, optional dummy cycle for a skip
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
            cmd_q   <= `CMD_RST;
            skip_q  <= 1'b0;
            cyc_q   <= 2'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (wr_fire && AWADDR == `OFF_CMD && WSTRB[1:0] == 2'h3) begin
                        cmd_q   <= WDATA[`CMD_W-1:0];
                        skip_q  <= 1'b0;
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH: state_q <= S_EXEC;
                S_EXEC: begin
                    skip_q <= alu.skip;
                    cyc_q  <= alu.skip ? `CYC_TWO : `CYC_ONE;
                    state_q <= alu.skip ? S_DUMMY : S_IDLE;
                end
                S_DUMMY: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            acc_q   <= `BYTE_RST;
            flags_q <= '0;
        end else if (state_q == S_EXEC) begin
            flags_q <= alu.flags;
            if (alu.wr_acc) begin
                acc_q <= alu.data;
            end
        end else if (wr_fire && WSTRB[0]) begin
            if (AWADDR == `OFF_ACC) begin
                acc_q <= WDATA[7:0];
            end
            if (AWADDR == `OFF_FLAGS) begin
                flags_q <= WDATA[5:0];
            end
        end
    end

    // table pointers; the low pointer wraps without touching the high one
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            table_pointer_low_q <= `BYTE_RST;
            table_pointer_high_q <= 1'b0;
            page_q <= 1'b0;
            table_read_upper_byte_q <= `BYTE_RST;
        end else begin
            if (state_q == S_FETCH && preinc) begin
                table_pointer_low_q <= table_pointer_low_nx;
            end else if (wr_fire && WSTRB[0] && AWADDR == `OFF_TABLE_POINTER_LOW) begin
                table_pointer_low_q <= WDATA[7:0];
            end
            if (wr_fire && WSTRB[0] && AWADDR == `OFF_TABLE_POINTER_HIGH) begin
                table_pointer_high_q <= WDATA[0];
            end
            if (wr_fire && WSTRB[0] && AWADDR == `OFF_PAGE) begin
                page_q <= WDATA[0];
            end
            if (state_q == S_EXEC && is_tab) begin
                table_read_upper_byte_q <= pm_rdata[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_subm_carry: assert property (
        (state_q == S_EXEC && op == `OP_SUBM) |-> dm_we && dm_wdata == acc_q - dm_rdata
        ##1 flags_q.c == ($past(acc_q) >= $past(dm_rdata)))
        else $error("subtract result or carry wrong");
    chk_subm_flags: assert property (
        (state_q == S_EXEC && op == `OP_SUBM) |=>
        flags_q.z == ($past(acc_q) == $past(dm_rdata)) && flags_q.cz == flags_q.z
        && flags_q.sc == ($signed($past(acc_q)) < $signed($past(dm_rdata))))
        else $error("subtract flags wrong");
    chk_swap_mem: assert property (
        (state_q == S_EXEC && op == `OP_SWAP) |-> dm_we
        && dm_wdata == {dm_rdata[3:0], dm_rdata[7:4]} ##1 $stable(flags_q))
        else $error("in-place swap wrong");
    chk_swap_acc: assert property (
        (state_q == S_EXEC && op == `OP_SWAPA) |-> !dm_we
        ##1 acc_q == {$past(dm_rdata[3:0]), $past(dm_rdata[7:4])} && $stable(flags_q))
        else $error("swap to accumulator wrong");
    chk_zero_skip: assert property (
        (state_q == S_EXEC && op == `OP_SZ && dm_rdata == `BYTE_RST) |=>
        state_q == S_DUMMY ##1 state_q == S_IDLE && cyc_q == `CYC_TWO)
        else $error("zero skip timing wrong");
    chk_copy_skip: assert property (
        (state_q == S_EXEC && op == `OP_SZA) |=>
        acc_q == $past(dm_rdata) && skip_q == ($past(dm_rdata) == `BYTE_RST))
        else $error("copy and skip wrong");
    chk_bit_skip: assert property (
        (state_q == S_EXEC && op == `OP_SZBIT) |=>
        skip_q != $past(dm_rdata[cmd_q[`CMD_BIT_HI:`CMD_BIT_LO]])
        && $stable(flags_q))
        else $error("bit skip wrong");
    chk_table_high: assert property (
        (state_q == S_EXEC && is_tab) |-> dm_wdata == pm_rdata[7:0]
        ##1 table_read_upper_byte_q == $past(pm_rdata[15:8]))
        else $error("table read bytes wrong");
    chk_preinc_ptr: assert property (
        (state_q == S_FETCH && preinc) |=> table_pointer_low_q == $past(table_pointer_low_q) + 8'h01
        && $stable(table_pointer_high_q))
        else $error("pointer pre-increment wrong");
    chk_xor_acc: assert property (
        (state_q == S_EXEC && op == `OP_XOR) |=> acc_q == ($past(acc_q) ^ $past(dm_rdata))
        && flags_q.c == $past(flags_q.c) && flags_q.ov == $past(flags_q.ov))
        else $error("xor to accumulator wrong");
endmodule

// file: verification/ext_exec_unit_tb_top.sv
`timescale 1ns/10ps
`include "ext_exec_defines.svh"
module ext_exec_unit_tb_top;
    import ext_exec_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [31:0] last_data;
    logic [1:0]  last_resp;
    logic [31:0] seed = 32'h00003E98;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;

    ext_exec_unit dut (
        .CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;

    // ceiling well above the ~3300 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // ready comes on both channels in the same cycle, yet each is released on its own
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) begin
                awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (wready) begin
                wvalid <= 1'b0;
                w = 1'b1;
            end
            if (bvalid && aw && w) begin
                last_resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] ad);
        logic ar;
        ar = 1'b0;
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) begin
                arvalid <= 1'b0;
                ar = 1'b1;
            end
            if (rvalid && ar) begin
                last_data = rdata;
                last_resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] pidx(input logic [3:0] op, input logic [7:0] lp,
                                        input logic hp, input logic pg);
        case (op)
            `OP_TABRDL:  return {`LAST_PAGE, lp};
            `OP_ITABRD:  return {hp, lp + 8'h01};
            `OP_ITABRDL: return {`LAST_PAGE, lp + 8'h01};
            default:     return {pg, lp};
        endcase
    endfunction

    function automatic void model(input logic [3:0] op, input logic [2:0] b,
                                  input logic [7:0] a, input logic [7:0] m,
                                  input logic [5:0] f, output logic [7:0] ea,
                                  output logic [7:0] em, output logic [5:0] ef,
                                  output logic sk, output logic tb);
        logic [7:0] r;
        logic       ov;
        r = a - m;
        ov = (a[7] ^ m[7]) & (r[7] ^ a[7]);
        ea = a;
        em = m;
        ef = f;
        sk = 1'b0;
        tb = 1'b0;
        case (op)
            `OP_SUBM: begin
                em = r;
                ef = {r == 8'h00, ov ^ r[7], ov, r == 8'h00, a[3:0] >= m[3:0], a >= m};
            end
            `OP_SWAP:  em = {m[3:0], m[7:4]};
            `OP_SWAPA: ea = {m[3:0], m[7:4]};
            `OP_SZ:    sk = (m == 8'h00);
            `OP_SZA: begin
                ea = m;
                sk = (m == 8'h00);
            end
            `OP_SZBIT: sk = ~m[b];
            `OP_TABRD, `OP_TABRDL, `OP_ITABRD, `OP_ITABRDL: tb = 1'b1;
            `OP_XOR: begin
                ea = a ^ m;
                ef[2] = ((a ^ m) == 8'h00);
            end
            `OP_XORM: begin
                em = a ^ m;
                ef[2] = ((a ^ m) == 8'h00);
            end
            default: ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0]  a, m, lp, ea, em, th;
        logic [5:0]  f, ef;
        logic [4:0]  da;
        logic [3:0]  op;
        logic [2:0]  b;
        logic [15:0] pw;
        logic        hp, pg, sk, tb;
        th = `BYTE_RST;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h020);
        check({30'h0, last_resp}, {30'h0, `RESP_SLVERR});
        check(last_data, 32'h00000000);
        wr(12'h020, 32'hFFFFFFFF, 4'hF);
        check({30'h0, last_resp}, {30'h0, `RESP_SLVERR});
        // three passes over every code: zero operand, random, operand equal to acc
        for (int i = 0; i < 48; i++) begin
            x = rnd();
            y = rnd();
            op = i[3:0];
            a = x[7:0];
            m = (i < 16) ? 8'h00 : ((i < 32) ? x[15:8] : a);
            b = x[18:16];
            da = x[23:19];
            hp = x[24];
            pg = x[25];
            f = x[31:26];
            lp = (i == 40) ? 8'hFF : y[7:0];
            pw = y[23:8];
            wr(12'h100 + {da, 2'b00}, {24'h0, m}, 4'h1);
            wr(`OFF_ACC, {24'h0, a}, 4'h1);
            wr(`OFF_FLAGS, {26'h0, f}, 4'h1);
            wr(`OFF_TABLE_POINTER_LOW, {24'h0, lp}, 4'h1);
            wr(`OFF_TABLE_POINTER_HIGH, {31'h0, hp}, 4'h1);
            wr(`OFF_PAGE, {31'h0, pg}, 4'h1);
            wr(12'h800 + {pidx(op, lp, hp, pg), 2'b00}, {16'h0, pw}, 4'h3);
            model(op, b, a, m, f, ea, em, ef, sk, tb);
            // table forms overwrite the operand byte with the fetched low byte
            if (tb) begin
                em = pw[7:0];
            end
            wr(`OFF_CMD, {19'h0, da, 1'b0, b, op}, 4'h3);
            rd(`OFF_STAT);
            check(last_data, {28'h0, sk ? `CYC_TWO : `CYC_ONE, sk, 1'b0});
            rd(`OFF_ACC);
            check(last_data, {24'h0, ea});
            rd(`OFF_FLAGS);
            check(last_data, {26'h0, ef});
            rd(12'h100 + {da, 2'b00});
            check(last_data, {24'h0, em});
            if (tb) begin
                th = pw[15:8];
            end
            rd(`OFF_TABLE_READ_UPPER_BYTE);
            check(last_data, {24'h0, th});
            // low pointer wraps without carrying into the page bit
            rd(`OFF_TABLE_POINTER_LOW);
            check(last_data, {24'h0, lp + {7'h0, op == `OP_ITABRD || op == `OP_ITABRDL}});
        end
        end_of_test();
    end
endmodule
